// >>> design/dps_pd_ctrl.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "dps_map.svh"
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - hot case: refresh interval halved
// - hot self refresh needs auto or extended bit
// - bit 7 picks normal or extended range
// - auto bit set forces extended bit zero
// - cke low with nop enters power-down
// - no cke drop during mrs/read/write
// - act/pre/ref one clock, mrs tMOD
// - slow exit makes odt asynchronous
// - nop until buffer-disable delay passes
// - unlocked dll entry needs dll reset
// - power-down under nine normal refresh intervals
// - exit with nop then wait tXP
////////////////////////////////////////////////////////////////////////////
module dps_pd_ctrl #(
   parameter int CLK_MHZ = 125,
   parameter int PD_MAX_CYC = 9 * 975
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic [3:0]           addr,
   input  wire logic [15:0]          wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output logic      [15:0]          rdata,
   input  wire logic                 cmd_valid,
   input  wire dps_pkg::dps_cmd_e    cmd_code,
   input  wire logic                 ddr_ck,
   output logic                      ddr_cke,
   output logic                      cmd_nop,
   output logic                      ddr_odt_async,
   output logic      [15:0]          mr2_val,
   output logic                      dll_reset_req,
   output logic                      refresh_fast
);
   localparam int TXPDLL_NS_CYC =
      (`DPS_TXPDLL_PS + `DPS_CLK_PS - 1) / `DPS_CLK_PS;
   localparam int TXPDLL_CYC = (TXPDLL_NS_CYC > `DPS_TXPDLL_CK) ?
      TXPDLL_NS_CYC : `DPS_TXPDLL_CK;
   localparam int CPDED_CYC = 1;
   localparam int TXP_CYC = 3;

   typedef enum logic [2:0] {
      ST_ACT, ST_ENTER, ST_PD, ST_SR, ST_EXIT
   } dps_st_e;

   logic [15:0]          ctrl_r;
   logic [7:0]           lat_r;
   logic [7:0]           temp_r;
   logic [15:0]          tim_r;
   logic [15:0]          rdata_nxt;
   dps_st_e              st_r;
   dps_pkg::dps_cnt_t    wait_r;
   dps_pkg::dps_cnt_t    dly_r;
   logic [15:0]          pd_cnt_r;
   logic                 ref_since_exit_r;
   logic                 dll_unlocked_entry_r;
   logic                 ck_s;
   logic                 ck_d_r;
   logic                 ck_rise;
   logic                 hot;
   logic                 sr_ok;
   logic                 illegal;
   logic                 asr_eff;
   logic                 srt_eff;
   logic [7:0]           rl;
   logic [7:0]           wl;
   logic [7:0]           wr_ck;
   logic [7:0]           tmod;
   logic [7:0]           burst;

   dps_sync #(.W(1)) u_ck_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .din     (ddr_ck),
      .dout    (ck_s)
   );

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         ck_d_r <= 1'b0;
      else
         ck_d_r <= ck_s;
   end
   assign ck_rise = ck_s & ~ck_d_r;

   ////////////////////////////////////////////////////////////////////////
   // latency fields: rl[3:0]/wl[7:4] of lat_r, wr/tmod in tim_r
   assign rl    = {4'h0, lat_r[3:0]} + 8'h05;
   assign wl    = {4'h0, lat_r[7:4]} + 8'h05;
   assign wr_ck = tim_r[7:0];
   assign tmod  = tim_r[15:8];
   assign burst = ctrl_r[`DPS_CTRL_BC4MRS] ? 8'h02 : 8'h04;

   // clocks that must pass after a command before cke may drop
   function automatic dps_pkg::dps_cnt_t pden(dps_pkg::dps_cmd_e c);
      case (c)
         dps_pkg::DPS_CMD_ACT,
         dps_pkg::DPS_CMD_PRE,
         dps_pkg::DPS_CMD_REF:  pden = 8'h01;
         dps_pkg::DPS_CMD_RD:   pden = rl + 8'h05;
         dps_pkg::DPS_CMD_WR:   pden = wl + burst + wr_ck;
         dps_pkg::DPS_CMD_WRAP: pden = wl + burst + wr_ck + 8'h01;
         dps_pkg::DPS_CMD_MRS:  pden = tmod;
         default:               pden = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // temperature and self refresh settings
   assign hot     = temp_r > `DPS_HOT_LIMIT;
   assign asr_eff = ctrl_r[`DPS_CTRL_ASR];
   // extended bit only meaningful with auto off
   assign srt_eff = ctrl_r[`DPS_CTRL_SRT] & ~asr_eff;
   assign illegal = ctrl_r[`DPS_CTRL_SRT] & asr_eff;
   assign sr_ok   = ~hot | asr_eff | srt_eff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mr2_val      <= 16'h0000;
         refresh_fast <= 1'b0;
      end else begin
         mr2_val <= 16'h0000;
         mr2_val[`DPS_MR2_ASR_BIT] <= asr_eff;
         mr2_val[`DPS_MR2_SRT_BIT] <= srt_eff;
         refresh_fast <= hot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_r <= 16'h0080;
         lat_r  <= `DPS_RESET_LAT;
         temp_r <= 8'h00;
         tim_r  <= `DPS_RESET_TIMING;
      end else begin
         // requests clear at exit; a stale exit bit dies while active
         if (st_r == ST_ACT)
            ctrl_r[`DPS_CTRL_PD_EXIT] <= 1'b0;
         if (st_r == ST_EXIT) begin
            ctrl_r[`DPS_CTRL_PD_REQ] <= 1'b0;
            ctrl_r[`DPS_CTRL_SR_REQ] <= 1'b0;
            ctrl_r[`DPS_CTRL_PD_EXIT] <= 1'b0;
         end
         if (wr_stb) begin
            case (addr)
               `DPS_REG_CTRL:   ctrl_r <= wdata;
               `DPS_REG_LAT:    lat_r  <= wdata[7:0];
               `DPS_REG_TEMP:   temp_r <= wdata[7:0];
               `DPS_REG_TIMING: tim_r  <= wdata;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      rdata_nxt = 16'h0000;
      case (addr)
         `DPS_REG_CTRL:   rdata_nxt = ctrl_r;
         `DPS_REG_LAT:    rdata_nxt = {8'h00, lat_r};
         `DPS_REG_TEMP:   rdata_nxt = {8'h00, temp_r};
         `DPS_REG_TIMING: rdata_nxt = tim_r;
         `DPS_REG_MR2:    rdata_nxt = mr2_val;
         `DPS_REG_STATUS: begin
            rdata_nxt[`DPS_ST_CKE]       = ddr_cke;
            rdata_nxt[`DPS_ST_PD]        = st_r == ST_PD;
            rdata_nxt[`DPS_ST_SR]        = st_r == ST_SR;
            rdata_nxt[`DPS_ST_DBL_REF]   = refresh_fast;
            rdata_nxt[`DPS_ST_SR_OK]     = sr_ok;
            rdata_nxt[`DPS_ST_ODT_ASYNC] = ddr_odt_async;
            rdata_nxt[`DPS_ST_DLL_RST]   = dll_reset_req;
            rdata_nxt[`DPS_ST_ILLEGAL]   = illegal;
            rdata_nxt[`DPS_ST_HOT]       = hot;
            rdata_nxt[`DPS_ST_BUSY]      = wait_r != 8'h00;
         end
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         rdata <= 16'h0000;
      else if (rd_stb)
         rdata <= rdata_nxt;
      else
         rdata <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // command hold-off counter, counted in link clocks
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         wait_r <= 8'h00;
      else if (cmd_valid && cmd_code != dps_pkg::DPS_CMD_NOP)
         wait_r <= pden(cmd_code);
      else if (st_r == ST_EXIT && ref_since_exit_r)
         wait_r <= wait_r;
      else if (ck_rise && wait_r != 8'h00)
         wait_r <= wait_r - 8'h01;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         ref_since_exit_r <= 1'b0;
      else if (st_r == ST_ENTER)
         ref_since_exit_r <= 1'b0;
      else if (cmd_valid && cmd_code == dps_pkg::DPS_CMD_REF)
         ref_since_exit_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // power-down sequencer
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_r                 <= ST_ACT;
         ddr_cke              <= 1'b1;
         cmd_nop              <= 1'b0;
         ddr_odt_async        <= 1'b0;
         dly_r                <= 8'h00;
         pd_cnt_r             <= 16'h0000;
         dll_unlocked_entry_r <= 1'b0;
         dll_reset_req        <= 1'b0;
      end else begin
         if (wr_stb && addr == `DPS_REG_CTRL && wdata[`DPS_CTRL_DLLLOCK])
            dll_reset_req <= 1'b0;
         if (ck_rise && dly_r != 8'h00)
            dly_r <= dly_r - 8'h01;
         case (st_r)
            ST_ACT: begin
               cmd_nop <= 1'b0;
               if (dly_r == 8'h00 && wait_r == 8'h00 && !cmd_valid &&
                   (ctrl_r[`DPS_CTRL_PD_REQ] ||
                    (ctrl_r[`DPS_CTRL_SR_REQ] && sr_ok))) begin
                  // slow exit: odt goes async before cke falls
                  ddr_odt_async <= ctrl_r[`DPS_CTRL_SLOWEXIT];
                  cmd_nop <= 1'b1;
                  st_r    <= ST_ENTER;
               end
            end
            ST_ENTER: if (ck_rise) begin
               ddr_cke  <= 1'b0;
               dll_unlocked_entry_r <= ~ctrl_r[`DPS_CTRL_DLLLOCK];
               dly_r    <= 8'(CPDED_CYC);
               pd_cnt_r <= 16'h0000;
               st_r     <= (ctrl_r[`DPS_CTRL_SR_REQ] && sr_ok) ?
                           ST_SR : ST_PD;
            end
            ST_PD, ST_SR: begin
               if (ck_rise)
                  pd_cnt_r <= pd_cnt_r + 16'h0001;
               if (dly_r == 8'h00 && ck_rise &&
                   (ctrl_r[`DPS_CTRL_PD_EXIT] ||
                    (st_r == ST_PD &&
                     pd_cnt_r >= 16'(PD_MAX_CYC - 1)))) begin
                  ddr_cke <= 1'b1;
                  dly_r   <= 8'(TXPDLL_CYC);
                  st_r    <= ST_EXIT;
               end
            end
            ST_EXIT: if (dly_r == 8'h00 ||
                         (!ddr_odt_async &&
                          dly_r <= 8'(TXPDLL_CYC - TXP_CYC))) begin
               ddr_odt_async <= 1'b0;
               dll_reset_req <= dll_unlocked_entry_r;
               cmd_nop       <= 1'b0;
               // dly_r runs on so re-entry waits the whole relock time
               st_r          <= ST_ACT;
            end
            default: st_r <= ST_ACT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_cke_hold;
      @(posedge ref_clk) disable iff (reset)
      (wait_r != 8'h00) |-> !$fell(ddr_cke);
   endproperty
   a_cke_hold: assert property (p_cke_hold)
      else $error("cke dropped while command wait pending");

   property p_nop_at_entry;
      @(posedge ref_clk) disable iff (reset)
      $fell(ddr_cke) |-> cmd_nop;
   endproperty
   a_nop_at_entry: assert property (p_nop_at_entry)
      else $error("cke fell without nop");

   property p_rd_wait;
      @(posedge ref_clk) disable iff (reset)
      (cmd_valid && cmd_code == dps_pkg::DPS_CMD_RD) |=>
         (wait_r == rl + 8'h05);
   endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("read hold-off wrong");

   property p_wrap_wait;
      @(posedge ref_clk) disable iff (reset)
      (cmd_valid && cmd_code == dps_pkg::DPS_CMD_WRAP) |=>
         (wait_r == wl + burst + wr_ck + 8'h01);
   endproperty
   a_wrap_wait: assert property (p_wrap_wait)
      else $error("write ap hold-off wrong");

   property p_mr2_legal;
      @(posedge ref_clk) disable iff (reset)
      mr2_val[`DPS_MR2_ASR_BIT] |-> !mr2_val[`DPS_MR2_SRT_BIT];
   endproperty
   a_mr2_legal: assert property (p_mr2_legal)
      else $error("auto and extended bits both set");

   property p_sr_perm;
      @(posedge ref_clk) disable iff (reset)
      $rose(st_r == ST_SR) |-> $past(sr_ok);
   endproperty
   a_sr_perm: assert property (p_sr_perm)
      else $error("self refresh entered while hot without permission");

   property p_dbl_ref;
      @(posedge ref_clk) disable iff (reset)
      $changed(temp_r) |=> (refresh_fast == $past(hot));
   endproperty
   a_dbl_ref: assert property (p_dbl_ref)
      else $error("refresh rate not following temperature");

   property p_pd_max;
      @(posedge ref_clk) disable iff (reset)
      (st_r == ST_PD) |-> (pd_cnt_r <= 16'(PD_MAX_CYC));
   endproperty
   a_pd_max: assert property (p_pd_max)
      else $error("power-down held too long");

   property p_odt_slow;
      @(posedge ref_clk) disable iff (reset)
      ($fell(ddr_cke) && ctrl_r[`DPS_CTRL_SLOWEXIT]) |-> ddr_odt_async;
   endproperty
   a_odt_slow: assert property (p_odt_slow)
      else $error("odt not async at slow entry");
endmodule

// >>> inc/dps_map.svh
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
// software register offsets (word index on the register port)
`define DPS_REG_CTRL      4'h0
`define DPS_REG_LAT       4'h1
`define DPS_REG_TEMP      4'h2
`define DPS_REG_STATUS    4'h3
`define DPS_REG_MR2       4'h4
`define DPS_REG_TIMING    4'h5
// ctrl fields
`define DPS_CTRL_PD_REQ   0
`define DPS_CTRL_PD_EXIT  1
`define DPS_CTRL_SR_REQ   2
`define DPS_CTRL_ASR      3
`define DPS_CTRL_SRT      4
`define DPS_CTRL_BC4MRS   5
`define DPS_CTRL_SLOWEXIT 6
`define DPS_CTRL_DLLLOCK  7
// mode register 2 bit positions
`define DPS_MR2_ASR_BIT   6
`define DPS_MR2_SRT_BIT   7
// status fields
`define DPS_ST_CKE        0
`define DPS_ST_PD         1
`define DPS_ST_SR         2
`define DPS_ST_DBL_REF    3
`define DPS_ST_SR_OK      4
`define DPS_ST_ODT_ASYNC  5
`define DPS_ST_DLL_RST    6
`define DPS_ST_ILLEGAL    7
`define DPS_ST_HOT        8
`define DPS_ST_BUSY       9
// timing figures
`define DPS_CLK_PS        8000
`define DPS_TXPDLL_PS     24000
`define DPS_TXPDLL_CK     10
`define DPS_TREFI_NORM_NS 7800
`define DPS_TREFI_HOT_NS  3900
`define DPS_PDMAX_MULT    9
`define DPS_HOT_LIMIT     8'h55
`define DPS_MAX_LIMIT     8'h5f
`define DPS_RESET_LAT     8'h0b
`define DPS_RESET_TIMING  16'h0c05
`endif

// >>> inc/dps_pkg.sv
package dps_pkg;
   typedef enum logic [2:0] {
      DPS_CMD_NOP, DPS_CMD_ACT, DPS_CMD_PRE, DPS_CMD_REF,
      DPS_CMD_RD, DPS_CMD_WR, DPS_CMD_WRAP, DPS_CMD_MRS
   } dps_cmd_e;
   typedef logic [7:0] dps_cnt_t;
endpackage

// >>> design/dps_sync.sv
`timescale 1ns/100ps
module dps_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // meta_r feeds dout only
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// >>> sim/dps_dram_model.sv
`timescale 1ns/100ps
module dps_dram_model (
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic              ddr_ck,
   input  wire logic              ddr_cke,
   input  wire logic              cmd_nop,
   input  wire logic              cmd_valid,
   input  wire dps_pkg::dps_cmd_e cmd_code,
   input  wire logic [15:0]       mr2_val,
   input  wire logic              fast_exit,
   output logic      [7:0]        viol_r
);
   logic cke_r;
   logic pd_r;
   logic open_r;
   logic act_pd_r;
   logic dll_off_r;
   logic bad_edge;
   logic bad_mr2;
   // row state only; commands inside power-down never reach the array
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         open_r <= 1'b0;
      end else if (cmd_valid && !pd_r) begin
         if (cmd_code == dps_pkg::DPS_CMD_ACT) begin
            open_r <= 1'b1;
         end else if (cmd_code == dps_pkg::DPS_CMD_PRE) begin
            open_r <= 1'b0;
         end
      end
   end
   // a cke edge must travel with a nop on the bus
   assign bad_edge = (ddr_cke != cke_r) && !cmd_nop;
   // both temperature bits set is illegal; either bit allows hot refresh
   assign bad_mr2 = mr2_val[6] && mr2_val[7];
   always_ff @(posedge ddr_ck or posedge reset) begin
      if (reset) begin
         cke_r <= 1'b1;
         pd_r <= 1'b0;
         act_pd_r <= 1'b0;
         dll_off_r <= 1'b0;
         viol_r <= 8'h00;
      end else begin
         cke_r <= ddr_cke;
         pd_r <= !ddr_cke;
         if (cke_r && !ddr_cke) begin
            act_pd_r <= open_r;
            dll_off_r <= !open_r && !fast_exit;
         end
         viol_r <= viol_r + 8'(bad_edge) + 8'(bad_mr2);
      end
   end
endmodule

// >>> sim/test_dps_pd_ctrl.sv
`timescale 1ns/100ps
`include "dps_map.svh"
module test_dps_pd_ctrl;
   localparam int PD_MAX = 40;
   typedef struct {
      logic [3:0]  wa;
      logic [15:0] wd;
      logic [3:0]  ra;
      logic [15:0] m;
      logic [15:0] e;
   } dps_row_s;
   logic              ref_clk = 1'b0;
   logic              reset = 1'b1;
   logic              ddr_ck = 1'b0;
   logic [3:0]        addr = 4'h0;
   logic [15:0]       wdata = 16'h0000;
   logic              wr_stb = 1'b0;
   logic              rd_stb = 1'b0;
   logic              cmd_valid = 1'b0;
   dps_pkg::dps_cmd_e cmd_code = dps_pkg::DPS_CMD_NOP;
   logic [15:0]       rdata;
   logic [15:0]       mr2_val;
   logic              ddr_cke;
   logic              cmd_nop;
   logic              ddr_odt_async;
   logic              dll_reset_req;
   logic              refresh_fast;
   logic [7:0]        viol;
   logic [15:0]       ctrl_img = 16'h0080;
   logic [7:0]        temp = 8'h00;
   logic [15:0]       r;
   int                num_errors = 0;
   int                checks = 0;
   int                ck_n = 0;
   int                n;
   dps_row_s rows[10] = '{
      '{4'h2, 16'h0055, 4'h3, 16'h0108, 16'h0000},
      '{4'h2, 16'h0056, 4'h3, 16'h0108, 16'h0108},
      '{4'h0, 16'h0080, 4'h3, 16'h0010, 16'h0000},
      '{4'h0, 16'h0088, 4'h3, 16'h0010, 16'h0010},
      '{4'h0, 16'h0088, 4'h4, 16'h00c0, 16'h0040},
      '{4'h0, 16'h0090, 4'h4, 16'h00c0, 16'h0080},
      '{4'h0, 16'h0098, 4'h4, 16'h00c0, 16'h0040},
      '{4'h0, 16'h0080, 4'h4, 16'h00c0, 16'h0000},
      '{4'h2, 16'h0055, 4'h3, 16'h0010, 16'h0010},
      '{4'hf, 16'h1234, 4'hf, 16'hffff, 16'h0000}};
   // lat 0x0b gives rl 16, wl 5; timing gives wr 5, mode delay 12
   dps_pkg::dps_cmd_e pc[10] = '{dps_pkg::DPS_CMD_NOP, dps_pkg::DPS_CMD_ACT,
      dps_pkg::DPS_CMD_PRE, dps_pkg::DPS_CMD_REF, dps_pkg::DPS_CMD_RD,
      dps_pkg::DPS_CMD_WR, dps_pkg::DPS_CMD_WR, dps_pkg::DPS_CMD_WRAP,
      dps_pkg::DPS_CMD_WRAP, dps_pkg::DPS_CMD_MRS};
   logic [15:0] pcr[10] = '{16'h0080, 16'h0080, 16'h00c0, 16'h0000,
      16'h0080, 16'h0080, 16'h00a0, 16'h0080, 16'h00a0, 16'h0080};
   int pmn[10] = '{0, 1, 1, 1, 21, 14, 12, 15, 13, 12};

   always #4 ref_clk = ~ref_clk;
   // link clock offset so its edges never meet the system clock edges
   initial begin
      #13;
      forever #40 ddr_ck = ~ddr_ck;
   end
   always @(posedge ddr_ck) ck_n++;

   dps_pd_ctrl #(.PD_MAX_CYC(PD_MAX)) u_dps_pd_ctrl (.ref_clk(ref_clk),
      .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .ddr_ck(ddr_ck), .ddr_cke(ddr_cke),
      .cmd_nop(cmd_nop), .ddr_odt_async(ddr_odt_async), .mr2_val(mr2_val),
      .dll_reset_req(dll_reset_req), .refresh_fast(refresh_fast));
   dps_dram_model u_dps_dram_model (.ref_clk(ref_clk), .reset(reset),
      .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .cmd_nop(cmd_nop),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .mr2_val(mr2_val),
      .fast_exit(!ctrl_img[6]), .viol_r(viol));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      if (a == `DPS_REG_CTRL) ctrl_img = d;
      if (a == `DPS_REG_TEMP) temp = d[7:0];
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic cmd(input dps_pkg::dps_cmd_e c);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
   endtask
   // bounded wait on cke (sel 0) or the nop level (sel 1), in link clocks
   task automatic wt(input logic sel, input logic lvl, input int mx,
                     output int cnt);
      int i;
      i = 0;
      cnt = ck_n;
      while ((sel ? cmd_nop : ddr_cke) !== lvl && i < mx * 10) begin
         @(posedge ref_clk);
         #1 i++;
      end
      cnt = ck_n - cnt;
   endtask
   task automatic pd_cycle(input int k);
      int t0;
      int m;
      wr(`DPS_REG_CTRL, pcr[k]);
      cmd(pc[k]);
      t0 = ck_n;
      wr(`DPS_REG_CTRL, pcr[k] | 16'h0001);
      wt(1'b0, 1'b0, pmn[k] + 8, m);
      m = ck_n - t0;
      chk(ddr_cke === 1'b0 && m >= pmn[k] && m <= pmn[k] + 4, "holdoff");
      chk(cmd_nop === 1'b1, "nop in power-down");
      chk(ddr_odt_async === pcr[k][6], "odt mode");
      t0 = ck_n;
      wr(`DPS_REG_CTRL, pcr[k] | 16'h0003);
      wt(1'b0, 1'b1, 8, m);
      wt(1'b1, 1'b0, 20, m);
      m = ck_n - t0;
      chk(ddr_cke === 1'b1 && cmd_nop === 1'b0 &&
          m >= (pcr[k][6] ? 10 : 3), "exit");
      chk(ddr_odt_async === 1'b0, "odt after exit");
      chk(dll_reset_req === !pcr[k][7], "dll reset");
      wr(`DPS_REG_CTRL, 16'h0080);
      @(posedge ref_clk);
      #1 chk(dll_reset_req === 1'b0, "dll reset clear");
      // let the relock time run out before the next entry is timed
      repeat (10) @(posedge ddr_ck);
   endtask
   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, r);
         chk((r & rows[i].m) === rows[i].e, "register row");
         chk(refresh_fast === (temp > 8'h55), "refresh rate");
      end
      wr(`DPS_REG_CTRL, 16'h0098);
      rd(`DPS_REG_STATUS, r);
      chk(r[7] === 1'b1, "illegal pair flagged");
      // second reset in mid-run
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 chk(ddr_cke === 1'b1 && cmd_nop === 1'b0 && rdata === 16'h0000,
             "reset outputs");
      @(posedge ref_clk);
      reset <= 1'b0;
      ctrl_img = 16'h0080;
      temp = 8'h00;
      rd(`DPS_REG_CTRL, r);
      chk(r === 16'h0080, "ctrl reset");
      rd(`DPS_REG_LAT, r);
      chk(r === 16'h000b, "lat reset");
      rd(`DPS_REG_TIMING, r);
      chk(r === 16'h0c05, "timing reset");
      for (int k = 0; k < 10; k++) pd_cycle(k);
      // stay down with no exit: hardware must leave on its own
      wr(`DPS_REG_CTRL, 16'h0081);
      wt(1'b0, 1'b0, 8, n);
      wt(1'b0, 1'b1, PD_MAX + 8, n);
      chk(ddr_cke === 1'b1 && n >= PD_MAX - 1, "power-down limit");
      wt(1'b1, 1'b0, 20, n);
      wr(`DPS_REG_CTRL, 16'h0080);
      // hot self refresh is held back until a temperature bit is set
      wr(`DPS_REG_TEMP, 16'h0056);
      wr(`DPS_REG_CTRL, 16'h0084);
      wt(1'b0, 1'b0, 20, n);
      chk(ddr_cke === 1'b1, "hot self refresh held");
      wr(`DPS_REG_CTRL, 16'h008c);
      wt(1'b0, 1'b0, 8, n);
      chk(ddr_cke === 1'b0, "hot self refresh with auto");
      rd(`DPS_REG_STATUS, r);
      chk(r[2:1] === 2'b10, "self refresh state");
      wr(`DPS_REG_CTRL, 16'h008a);
      wt(1'b0, 1'b1, 8, n);
      wt(1'b1, 1'b0, 20, n);
      chk(ddr_cke === 1'b1 && cmd_nop === 1'b0, "self refresh exit");
      chk(viol === 8'h00, "device model");
      final_report;
   end
endmodule
